// ===== verilog/wdo_top.sv
// watchdog with write-once option registers, APB slave
// assumes: sys_clk is the crystal clock; sys_reset_req and cpu strobes are on sys_clk;
// test voltage detectors are asynchronous
// Contract
// - each option register takes only the first write after any reset
// - every reset clears option bits, except the voltage range bit
// - range bit cleared and re-armed for writing only by power-on reset
// - option registers decode at their addresses and read back anytime
// - oscillator runs in stop only when osc_run_in_stop is set
// - baud select picks bus clock when set, oscillator when clear
// - rate select: timeout 8176 cycles when set, 262128 when clear
// - monitor runs in stop if stop enable set and power disable clear
// - reset disable blocks monitor resets; power disable powers monitor down
// - range bit selects 5-V mode when set, 3-V when clear
// - stop recovery 32 cycles with short bit, else or via reset 4096
// - stop with stop enable clear is illegal opcode and resets
// - watchdog disable bit turns watchdog off entirely
// - 6-bit counter after 12-bit prescaler; overflow makes a reset
// - any clear-port write clears counter and prescaler stages 12 to 5
// - clear-port read returns the reset vector low byte
// - watchdog reset drives reset pin low 32 cycles, sets flag
// - stop entry stops watchdog clock and clears its prescaler
// - prescaler cleared 4096 cycles after power-on
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - test voltage monitor entry disables watchdog while voltage remains
// - blank-vector monitor entry disables watchdog until power-on reset
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module wdo_top #(
    parameter int WD_LONG  = wdo_pkg::WD_LONG_CYC,
    parameter int WD_SHORT = wdo_pkg::WD_SHORT_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [wdo_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        sys_reset_req,
    input  wire logic [7:0]                  reset_vector_lo,
    input  wire logic                        vector_fetch,
    input  wire logic                        stop_exec,
    input  wire logic                        wakeup_req,
    input  wire logic                        wakeup_by_reset,
    input  wire logic                        monitor_mode,
    input  wire logic                        monitor_blank_entry,
    input  wire logic                        test_voltage_irq,
    input  wire logic                        test_voltage_rst,
    output wdo_pkg::wdo_opt_out_t            opt_out,
    output logic                             in_stop,
    output logic                             stop_release,
    output logic                             illegal_stop_reset,
    output logic                             rst_pin_out,
    output logic                             rst_pin_oe
);
    localparam int FULL_W = wdo_pkg::CNT_W + wdo_pkg::PRE_W;
    localparam int SHRT_W = wdo_pkg::CNT_W + wdo_pkg::SHORT_PRE_W;

    initial begin
        if (WD_LONG < wdo_pkg::WD_PULSE_CYC || WD_LONG > (1 << FULL_W))
            $error("WD_LONG out of range");
        if (WD_SHORT < wdo_pkg::WD_PULSE_CYC || WD_SHORT > (1 << SHRT_W))
            $error("WD_SHORT out of range");
    end

    localparam logic [FULL_W-1:0] LONG_LAST  = FULL_W'(WD_LONG - 1);
    localparam logic [SHRT_W-1:0] SHORT_LAST = SHRT_W'(WD_SHORT - 1);
    localparam logic [12:0]       REC_SHORT  = 13'(wdo_pkg::REC_SHORT_CYC - 1);
    localparam logic [12:0]       REC_LONG   = 13'(wdo_pkg::REC_LONG_CYC - 1);
    localparam logic [12:0]       POR_LAST   = 13'(wdo_pkg::POR_CYC - 1);
    localparam logic [5:0]        PULSE_LAST = 6'(wdo_pkg::WD_PULSE_CYC - 1);

    // state
    logic [7:0]                  opt1;
    logic [7:0]                  opt2;
    logic                        range_bit;
    logic                        done1;
    logic                        done2;
    logic                        range_done;
    logic [wdo_pkg::PRE_W-1:0]   pre;
    logic [wdo_pkg::CNT_W-1:0]   cnt;
    logic [12:0]                 por_cnt;
    logic                        por_done;
    logic [12:0]                 rec_cnt;
    logic [5:0]                  pulse_cnt;
    logic                        pulsing;
    logic                        wd_flag;
    logic                        blank_latch;
    logic                        irq_meta;
    logic                        irq_sync;
    logic                        rst_meta;
    logic                        rst_sync;
    wdo_pkg::wdo_pm_t            pm;
    wdo_pkg::wdo_pm_t            next_pm;

    // bus decode
    wire apb_access = psel & penable;
    wire hit_opt1   = paddr == wdo_pkg::ADDR_OPT1;
    wire hit_opt2   = paddr == wdo_pkg::ADDR_OPT2;
    wire hit_stat   = paddr == wdo_pkg::ADDR_STATUS;
    wire hit_clr    = paddr == wdo_pkg::ADDR_CLEAR;
    wire mapped     = hit_opt1 | hit_opt2 | hit_stat | hit_clr;
    wire wr         = apb_access & pwrite;
    wire wr_opt1    = wr & hit_opt1 & ~done1;
    wire wr_opt2    = wr & hit_opt2 & ~done2;
    wire wr_range   = wr & hit_opt1 & ~range_done;
    wire wr_clear   = wr & hit_clr;

    assign pready  = 1'b1;
    assign pslverr = apb_access & ~mapped;

    // option fields
    wire rate_sel   = opt1[wdo_pkg::B1_RATE];
    wire lv_stop    = opt1[wdo_pkg::B1_LV_STOP];
    wire lv_rstd    = opt1[wdo_pkg::B1_LV_RSTD];
    wire lv_pwrd    = opt1[wdo_pkg::B1_LV_PWRD];
    wire short_stop_recovery      = opt1[wdo_pkg::B1_SHORT_STOP_RECOVERY];
    wire stop_en    = opt1[wdo_pkg::B1_STOP_EN];
    wire wd_dis     = opt1[wdo_pkg::B1_WD_DIS];
    wire osc_stop   = opt2[wdo_pkg::B2_OSC_STOP];
    wire baud_sel   = opt2[wdo_pkg::B2_BAUD_SEL];

    wire [7:0] opt1_view = {opt1[7:4], range_bit, opt1[2:0]};

    // internal reset: any system reset or our own overflow
    wire wd_fire;
    wire int_rst    = sys_reset_req | wd_fire;

    wire tst_hold   = monitor_mode & (irq_sync | rst_sync);
    wire wd_active  = ~wd_dis & ~tst_hold & ~blank_latch;
    wire wd_clocked = wd_active & (pm != wdo_pkg::WDO_STOP);

    // timeout compare: short rate looks at the low prescaler stages only
    wire [FULL_W-1:0] elapsed_full  = {cnt, pre};
    wire [SHRT_W-1:0] elapsed_short = {cnt, pre[wdo_pkg::SHORT_PRE_W-1:0]};
    wire at_limit = rate_sel ? (elapsed_short == SHORT_LAST)
                             : (elapsed_full == LONG_LAST);
    assign wd_fire = wd_clocked & at_limit & ~pulsing;

    wire pre_carry = rate_sel ? (&pre[wdo_pkg::SHORT_PRE_W-1:0]) : (&pre);
    wire por_tick  = ~por_done & (por_cnt == POR_LAST);
    wire pre_clear = int_rst | vector_fetch | por_tick | ~por_done
                   | (pm == wdo_pkg::WDO_STOP);

    // read mux
    wire [7:0] stat_view = {4'h0, blank_latch, wd_active, in_stop, wd_flag};
    wire [7:0] rd_byte = hit_opt1 ? opt1_view :
                         hit_opt2 ? opt2 :
                         hit_stat ? stat_view :
                         hit_clr  ? reset_vector_lo : 8'h00;

    // power mode sequencing
    wire stop_ok   = stop_exec & stop_en;
    wire stop_bad  = stop_exec & ~stop_en;
    wire rec_done  = rec_cnt == 13'h0000;
    wire [12:0] rec_load = (short_stop_recovery & ~wakeup_by_reset) ? REC_SHORT : REC_LONG;

    always_comb begin
        next_pm = pm;
        unique case (pm)
            wdo_pkg::WDO_RUN: begin
                if (stop_ok) begin
                    next_pm = wdo_pkg::WDO_STOP;
                end
            end
            wdo_pkg::WDO_STOP: begin
                if (wakeup_req) begin
                    next_pm = wdo_pkg::WDO_RECOVER;
                end
            end
            wdo_pkg::WDO_RECOVER: begin
                if (rec_done) begin
                    next_pm = wdo_pkg::WDO_RUN;
                end
            end
            default: next_pm = wdo_pkg::WDO_RUN;
        endcase
    end

    // outputs to other units
    assign in_stop = pm == wdo_pkg::WDO_STOP;
    assign opt_out.osc_enable               = ~in_stop | osc_stop;
    assign opt_out.serial_baud_clock_select = baud_sel;
    assign opt_out.lowvolt_power_on         = ~lv_pwrd & (~in_stop | lv_stop);
    assign opt_out.lowvolt_reset_enable     = ~lv_rstd & ~lv_pwrd;
    assign opt_out.lowvolt_range_select     = range_bit;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = pulsing;

    // test voltage synchronisers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            irq_meta <= test_voltage_irq;
            irq_sync <= irq_meta;
            rst_meta <= test_voltage_rst;
            rst_sync <= rst_meta;
        end
    end

    // option registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opt1  <= wdo_pkg::OPT_RESET;
            opt2  <= wdo_pkg::OPT_RESET;
            done1 <= 1'b0;
            done2 <= 1'b0;
        end else if (int_rst) begin
            opt1  <= wdo_pkg::OPT_RESET;
            opt2  <= wdo_pkg::OPT_RESET;
            done1 <= 1'b0;
            done2 <= 1'b0;
        end else begin
            if (wr_opt1) begin
                opt1  <= pwdata[7:0];
                done1 <= 1'b1;
            end
            if (wr_opt2) begin
                opt2  <= pwdata[7:0];
                done2 <= 1'b1;
            end
        end
    end

    // range bit lives on power-on reset only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            range_bit  <= 1'b0;
            range_done <= 1'b0;
        end else if (wr_range) begin
            range_bit  <= pwdata[wdo_pkg::B1_LV_RANGE];
            range_done <= 1'b1;
        end
    end

    // power-on settle count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            por_cnt  <= 13'h0000;
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt  <= por_cnt + 13'h0001;
            por_done <= por_tick;
        end
    end

    // prescaler and counter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pre <= '0;
        end else if (pre_clear) begin
            pre <= '0;
        end else if (wr_clear) begin
            pre[wdo_pkg::PRE_W-1:wdo_pkg::CLR_LO] <= '0;
        end else if (wd_clocked) begin
            pre <= pre + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (int_rst | wr_clear) begin
            cnt <= '0;
        end else if (wd_clocked & ~pre_clear & pre_carry) begin
            cnt <= cnt + 1'b1;
        end
    end

    // reset pin pulse and cause flag; set wins over clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pulsing   <= 1'b0;
            pulse_cnt <= 6'h00;
            wd_flag   <= 1'b0;
        end else begin
            if (wd_fire) begin
                pulsing   <= 1'b1;
                pulse_cnt <= 6'h00;
            end else if (pulsing) begin
                pulse_cnt <= pulse_cnt + 6'h01;
                pulsing   <= pulse_cnt != PULSE_LAST;
            end
            if (wd_fire) begin
                wd_flag <= 1'b1;
            end else if (sys_reset_req & ~pulsing) begin
                wd_flag <= 1'b0;
            end
        end
    end

    // blank-vector monitor latch
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blank_latch <= 1'b0;
        end else if (monitor_blank_entry) begin
            blank_latch <= 1'b1;
        end
    end

    // power mode and recovery
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pm                 <= wdo_pkg::WDO_RUN;
            rec_cnt            <= 13'h0000;
            stop_release       <= 1'b0;
            illegal_stop_reset <= 1'b0;
        end else begin
            pm                 <= next_pm;
            stop_release       <= (pm == wdo_pkg::WDO_RECOVER) & rec_done;
            illegal_stop_reset <= (pm == wdo_pkg::WDO_RUN) & stop_bad;
            if (in_stop & wakeup_req) begin
                rec_cnt <= rec_load;
            end else if (!rec_done) begin
                rec_cnt <= rec_cnt - 13'h0001;
            end
        end
    end

    // APB read data from flip-flops, loaded in the setup cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end
    end
endmodule

// ===== verilog/wdo_pkg.sv
// constants, field layouts and carriers of the watchdog with write-once options
// assumes: APB with 32-bit data, one aligned word per register
package wdo_pkg;
    localparam int             ADDR_W        = 18;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0]     IDX_OPT2      = 8'h1e;
    localparam logic [7:0]     IDX_OPT1      = 8'h1f;
    localparam logic [7:0]     IDX_STATUS    = 8'h20;
    localparam logic [15:0]    IDX_CLEAR     = 16'hffff;
    localparam logic [17:0]    ADDR_OPT2     = {8'h00, IDX_OPT2, 2'h0};
    localparam logic [17:0]    ADDR_OPT1     = {8'h00, IDX_OPT1, 2'h0};
    localparam logic [17:0]    ADDR_STATUS   = {8'h00, IDX_STATUS, 2'h0};
    localparam logic [17:0]    ADDR_CLEAR    = {IDX_CLEAR, 2'h0};
    localparam logic [7:0]     OPT_RESET     = 8'h00;

    // option_register_one bit positions
    localparam int             B1_RATE       = 7;
    localparam int             B1_LV_STOP    = 6;
    localparam int             B1_LV_RSTD    = 5;
    localparam int             B1_LV_PWRD    = 4;
    localparam int             B1_LV_RANGE   = 3;
    localparam int             B1_SHORT_STOP_RECOVERY      = 2;
    localparam int             B1_STOP_EN    = 1;
    localparam int             B1_WD_DIS     = 0;
    // option_register_two bit positions
    localparam int             B2_OSC_STOP   = 1;
    localparam int             B2_BAUD_SEL   = 0;
    // status register bit positions
    localparam int             BS_WD_FLAG    = 0;
    localparam int             BS_IN_STOP    = 1;
    localparam int             BS_WD_ACTIVE  = 2;
    localparam int             BS_MON_LATCH  = 3;

    // times in crystal clock cycles, then stage widths and the lowest cleared stage
    localparam int             WD_LONG_CYC   = 262128;
    localparam int             WD_SHORT_CYC  = 8176;
    localparam int             REC_SHORT_CYC = 32;
    localparam int             REC_LONG_CYC  = 4096;
    localparam int             POR_CYC       = 4096;
    localparam int             WD_PULSE_CYC  = 32;
    localparam int             PRE_W         = 12;
    localparam int             CNT_W         = 6;
    localparam int             SHORT_PRE_W   = 7;
    localparam int             CLR_LO        = 4;

    typedef enum logic [2:0] {
        WDO_RUN     = 3'b001,
        WDO_STOP    = 3'b010,
        WDO_RECOVER = 3'b100
    } wdo_pm_t;

    typedef struct packed {
        logic osc_enable;
        logic serial_baud_clock_select;
        logic lowvolt_power_on;
        logic lowvolt_reset_enable;
        logic lowvolt_range_select;
    } wdo_opt_out_t;
endpackage

// ===== testbench/wdo_cpu.sv
// partner model: the cpu core as an apb master for the option block
// assumes: xfer is entered just after a rising edge of sys_clk
`timescale 1ns/100ps
module wdo_cpu (
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [17:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    int hang;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        hang = 0;
    end
    task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                        output logic [7:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1)
            hang++;
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look like the last value
        pwdata <= ~pwdata;
        @(posedge sys_clk);
    endtask
endmodule

// ===== testbench/wdo_top_chk.sv
// port assertions for the watchdog with write-once options
// assumes: one clock, nrst asynchronous active low
`timescale 1ns/100ps
module wdo_chk (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [7:0]  reset_vector_lo,
    input wire logic        stop_exec,
    input wire logic        wakeup_req,
    input wire logic        in_stop,
    input wire logic        stop_release,
    input wire logic        illegal_stop_reset,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] oe_cnt;
    logic [12:0] rec_age;
    logic rec_wait;
    wire        acc = psel && penable;
    wire        mapped = paddr == wdo_pkg::ADDR_OPT1 || paddr == wdo_pkg::ADDR_OPT2 ||
                         paddr == wdo_pkg::ADDR_STATUS || paddr == wdo_pkg::ADDR_CLEAR;
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst)
            oe_cnt <= 8'h00;
        else
            oe_cnt <= rst_pin_oe ? oe_cnt + 8'h01 : 8'h00;
    // long recovery outlasts any delay range, so its age is counted here
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst) begin
            rec_wait <= 1'b0;
            rec_age  <= 13'h0000;
        end else if (in_stop && wakeup_req) begin
            rec_wait <= 1'b1;
            rec_age  <= 13'h0000;
        end else if (stop_release) begin
            rec_wait <= 1'b0;
        end else if (rec_wait) begin
            rec_age  <= rec_age + 13'h0001;
        end
    AST_STOP_FORK: assert property (stop_exec && !in_stop |=> in_stop != illegal_stop_reset)
        else $error("stop neither entered nor refused");
    AST_ILL_ONE: assert property (illegal_stop_reset |=> !illegal_stop_reset)
        else $error("illegal stop pulse too long");
    AST_REL_TIME: assert property (rec_wait |-> rec_age <= 13'h1004 &&
                                   (!stop_release || rec_age >= 13'h001f))
        else $error("stop recovery missing or early");
    AST_REL_ONE: assert property (stop_release |=> !stop_release && !in_stop)
        else $error("stop release pulse wrong");
    AST_PIN_LEN: assert property ($fell(rst_pin_oe) |-> oe_cnt == 8'h20)
        else $error("reset pin pulse not 32 cycles");
    AST_PIN_LOW: assert property (rst_pin_oe |-> !rst_pin_out)
        else $error("reset pin not driven low");
    AST_NO_WD_STOP: assert property (in_stop && $past(in_stop) |-> !$rose(rst_pin_oe))
        else $error("watchdog fired in stop");
    AST_ERR_MAP: assert property (acc |-> pslverr == !mapped)
        else $error("address decode wrong");
    AST_RD_VEC: assert property (acc && !pwrite && paddr == wdo_pkg::ADDR_CLEAR
                                 |-> prdata[7:0] == $past(reset_vector_lo))
        else $error("clear port read wrong");
    cover property (stop_exec && !in_stop ##1 in_stop);
    cover property (illegal_stop_reset);
    cover property ($fell(rst_pin_oe));
endmodule
bind wdo_top wdo_chk i_wdo_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .reset_vector_lo(reset_vector_lo),
    .stop_exec(stop_exec), .wakeup_req(wakeup_req), .in_stop(in_stop), .stop_release(stop_release),
    .illegal_stop_reset(illegal_stop_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));

// ===== testbench/test_watchdog_with_write_once_config.sv
// self-checking bench for the watchdog with write-once options
// assumes: wdo_cpu drives apb, wdo_chk is bound to wdo_top
`timescale 1ns/100ps
module test_watchdog_with_write_once_config;
    logic sys_clk, nrst, sys_reset_req, stop_exec, wakeup_req, wakeup_by_reset;
    logic psel, penable, pwrite, pready, pslverr, in_stop, stop_release, illegal_stop_reset;
    logic rst_pin_out, rst_pin_oe, e, rng, rngw, w1, w2;
    logic vector_fetch, monitor_mode, test_voltage_irq;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] reset_vector_lo, r, v, m1, m2;
    wdo_pkg::wdo_opt_out_t opt_out;
    int n_fail, comparisons, seed, k;
    wdo_cpu i_wdo_cpu (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // short sim timeouts: 64 with rate bit set
    wdo_top #(.WD_LONG(200), .WD_SHORT(64)) i_wdo_top (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_reset_req(sys_reset_req), .reset_vector_lo(reset_vector_lo),
        .vector_fetch(vector_fetch), .stop_exec(stop_exec), .wakeup_req(wakeup_req),
        .wakeup_by_reset(wakeup_by_reset), .monitor_mode(monitor_mode), .monitor_blank_entry(1'b0),
        .test_voltage_irq(test_voltage_irq), .test_voltage_rst(1'b0),
        .opt_out(opt_out), .in_stop(in_stop), .stop_release(stop_release),
        .illegal_stop_reset(illegal_stop_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // model of the write-once latches; range bit only rearmed by nrst
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        i_wdo_cpu.xfer(1'b1, a, d, r, e);
        if (a == wdo_pkg::ADDR_OPT1 && !w1) begin
            w1 = 1'b1;
            m1 = d & 8'hf7;
            rng = rngw ? rng : d[3];
            rngw = 1'b1;
        end
        if (a == wdo_pkg::ADDR_OPT2 && !w2) begin
            w2 = 1'b1;
            m2 = d;
        end
    endtask
    task automatic rd(input logic [17:0] a, input logic [7:0] x);
        i_wdo_cpu.xfer(1'b0, a, 8'h00, r, e);
        chk(32'(r), 32'(x));
    endtask
    function automatic logic [4:0] exp_opt(input logic st);
        exp_opt = {!st || m2[1], m2[0], !m1[4] && (!st || m1[6]), !m1[5] && !m1[4], rng};
    endfunction
    task automatic await(input logic s, input int lim);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((s ? stop_release : rst_pin_oe) !== 1'b1 && k < lim);
        if ((s ? stop_release : rst_pin_oe) !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic pulse_stop;
        stop_exec <= 1'b1;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        // look once the pulse and the state have settled
        @(negedge sys_clk);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {nrst, sys_reset_req, stop_exec, wakeup_req, wakeup_by_reset, rng, rngw, w1, w2} = '0;
        {vector_fetch, monitor_mode, test_voltage_irq} = '0;
        {m1, m2, reset_vector_lo} = '0;
        n_fail = 0;
        comparisons = 0;
        seed = 34;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        reset_vector_lo <= 8'($random(seed));
        @(posedge sys_clk);
        rd(wdo_pkg::ADDR_OPT1, 8'h00);
        rd(wdo_pkg::ADDR_OPT2, 8'h00);
        wr(wdo_pkg::ADDR_OPT2, 8'h03);
        wr(wdo_pkg::ADDR_OPT2, 8'h00);
        rd(wdo_pkg::ADDR_OPT2, m2);
        v = (8'($random(seed)) & 8'h78) | 8'h86;
        wr(wdo_pkg::ADDR_OPT1, v);
        wr(wdo_pkg::ADDR_OPT1, ~v);
        rd(wdo_pkg::ADDR_OPT1, m1 | {4'h0, rng, 3'h0});
        chk(32'(opt_out), 32'(exp_opt(1'b0)));
        // test voltage passes two synchroniser stages before it holds the watchdog off
        monitor_mode <= 1'b1;
        test_voltage_irq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(wdo_pkg::ADDR_STATUS, 8'h00);
        monitor_mode <= 1'b0;
        test_voltage_irq <= 1'b0;
        rd(wdo_pkg::ADDR_STATUS, {5'h00, !m1[0], 2'h0});
        i_wdo_cpu.xfer(1'b0, 18'h00040, 8'h00, r, e);
        chk(32'({e, r}), 32'h100);
        rd(wdo_pkg::ADDR_CLEAR, reset_vector_lo);
        pulse_stop();
        chk(32'(in_stop), 32'h1);
        chk(32'(opt_out), 32'(exp_opt(1'b1)));
        @(posedge sys_clk);
        wakeup_req <= 1'b1;
        @(posedge sys_clk);
        wakeup_req <= 1'b0;
        await(1'b1, 5000);
        chk(32'(k >= 31 && k <= 35), 32'h1);
        for (int i = 0; i < 150; i++) begin
            wr(wdo_pkg::ADDR_CLEAR, 8'($random(seed)));
            vector_fetch <= i == 75;
            repeat (26) @(posedge sys_clk);
            chk(32'(rst_pin_oe), 32'h0);
        end
        await(1'b0, 300);
        // 64 cycles from the last clear, up to 15 early; 27 of them already spent
        chk(32'(k >= 22 && k <= 39), 32'h1);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rst_pin_oe === 1'b1 && k < 100);
        chk(32'(k), 32'h20);
        i_wdo_cpu.xfer(1'b0, wdo_pkg::ADDR_STATUS, 8'h00, r, e);
        chk(32'(r[0]), 32'h1);
        sys_reset_req <= 1'b1;
        @(posedge sys_clk);
        sys_reset_req <= 1'b0;
        {m1, m2, w1, w2} = '0;
        @(posedge sys_clk);
        chk(32'(opt_out), 32'(exp_opt(1'b0)));
        wr(wdo_pkg::ADDR_OPT1, (~v & 8'hfc) | 8'h01);
        rd(wdo_pkg::ADDR_OPT1, m1 | {4'h0, rng, 3'h0});
        pulse_stop();
        chk(32'({illegal_stop_reset, in_stop}), 32'h2);
        k = 0;
        repeat (600) begin
            @(posedge sys_clk);
            k += rst_pin_oe;
        end
        chk(32'(k), 32'h0);
        chk(32'(i_wdo_cpu.hang), 32'h0);
        tally_and_finish();
    end
endmodule
